/* File: logic/ocp_top.sv */
// Output compare and PWM channels with APB register access
//
// Contract
// - Timer select bit 3, first timer default
// - Modes 1,2,3: match drives low, high, toggle
// - Simple modes compare primary against selected timer
// - Rollover without match leaves pin unchanged
// - Mode 4 single pulse, mode 5 continuous
// - Primary starts pulse, secondary ends it
// - Another single pulse needs mode 4 rewrite
// - PWM modes 6,7; primary read-only duty latch
// - Mode 7 fault low tri-states the pin
// - Read-only fault status at control bit 4
// - Fault holds until pin high and PWM mode rewritten
// - PWM period follows timer period plus one
// - Rollover: pin high, latch duty, timer flag
// - Zero duty keeps pin low all period
// - Duty above period keeps pin high
// - Sleep holds pin level, resumes on wake
// - Channel count configurable, four or two
// - Compare flag set in modes 1 to 5, not when off or in PWM
// - Idle runs only if allowed and timer runs
`timescale 1ns/1ps
`include "ocp_params.svh"
module ocp_top #(
  parameter int N_CH = 4
) (
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [1:0][15:0] TIMER_COUNT_I,
  input wire logic [1:0][15:0] TIMER_PERIOD_VALUE_I,
  input wire logic [1:0] TIMER_TICK_I,
  input wire logic [1:0] TIMER_RUN_BIT_I,
  input wire logic [1:0] TIMER_IDLE_RUN_I,
  input wire logic CPU_IDLE_I,
  input wire logic CPU_SLEEP_I,
  input wire logic [N_CH-1:0] FAULT_INPUT_PIN_I,
  output logic [N_CH-1:0] COMPARE_OUTPUT_PIN_O,
  output logic [N_CH-1:0] COMPARE_OUTPUT_PIN_OE_B_O,
  output logic [1:0] TIMER_FLAG_SET_O
);
  // Bus phase decode
  logic apb_setup;
  logic apb_wr;
  logic addr_ok;
  logic [11:0] idx;
  logic [N_CH-1:0] hit_sec;
  logic [N_CH-1:0] hit_pri;
  logic [N_CH-1:0] hit_ctl;
  logic hit_flag;
  logic any_hit;
  logic [15:0] rd_word;
  logic [31:0] prdata_r;
  logic err_r;

  // Per-channel views for readback and timer flags
  logic [N_CH-1:0][15:0] sec_v;
  logic [N_CH-1:0][15:0] pri_v;
  logic [N_CH-1:0][15:0] ctl_v;
  logic [N_CH-1:0] evt_v;
  logic [N_CH-1:0] roll_v;
  logic [N_CH-1:0] tsel_v;
  logic [N_CH-1:0] flt_s;
  logic [1:0] tflag_r;

  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign idx = PADDR_I[13:2];
  // Only word-aligned addresses in the low window decode
  assign addr_ok = (PADDR_I[15:14] == 2'h0) && (PADDR_I[1:0] == 2'h0);
  assign hit_flag = addr_ok && (idx == `OCP_IDX_FLAG);

  // Fault pins are asynchronous to the peripheral clock
  ocp_sync #(
    .W(N_CH)
  ) u_flt_sync (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .d_i(FAULT_INPUT_PIN_I),
    .q_o(flt_s)
  );

  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    localparam logic [11:0] SEC_IDX = 12'(`OCP_IDX_SEC_BASE + c * `OCP_IDX_CH_STRIDE);
    localparam logic [11:0] PRI_IDX = 12'(`OCP_IDX_PRI_BASE + c * `OCP_IDX_CH_STRIDE);
    localparam logic [11:0] CTL_IDX = 12'(`OCP_IDX_CTL_BASE + c * `OCP_IDX_CH_STRIDE);

    logic [2:0] mode_r;
    logic tsel_r;
    logic sidl_r;
    logic flt_r;
    logic rearm_r;
    logic evt_r;
    logic lvl_r;
    ocp_pkg::ocp_word_t pri_r;
    ocp_pkg::ocp_word_t sec_r;
    ocp_pkg::ocp_pulse_t pst_r;
    logic wr_ctl;
    logic wr_pwm;
    logic [2:0] wmode;
    logic simple;
    logic dual;
    logic pwm;
    logic can_run;
    logic step;
    logic roll;
    logic match;
    logic start_hit;
    logic stop_hit;
    logic cmp_evt;
    logic [15:0] cnt;
    logic [15:0] per;
    logic [15:0] nxt_cnt;
    ocp_pin_if pif ();

    assign hit_sec[c] = addr_ok && (idx == SEC_IDX);
    assign hit_pri[c] = addr_ok && (idx == PRI_IDX);
    assign hit_ctl[c] = addr_ok && (idx == CTL_IDX);
    assign wr_ctl = apb_wr && hit_ctl[c];
    assign wmode = PWDATA_I[2:0];
    assign wr_pwm = wr_ctl && (wmode[2:1] == 2'b11);

    // Mode classes
    assign simple = !mode_r[2] && (mode_r != `OCP_MODE_OFF);
    assign dual = (mode_r[2:1] == 2'b10);
    assign pwm = (mode_r[2:1] == 2'b11);

    // Selected time base
    assign cnt = TIMER_COUNT_I[tsel_r];
    assign per = TIMER_PERIOD_VALUE_I[tsel_r];

    // Idle keeps running only when neither side opts out
    assign can_run = TIMER_RUN_BIT_I[tsel_r] && !CPU_SLEEP_I &&
      !(CPU_IDLE_I && (sidl_r || !TIMER_IDLE_RUN_I[tsel_r]));

    // A disabled channel never sees a timer step
    assign step = (mode_r != `OCP_MODE_OFF) && TIMER_TICK_I[tsel_r] && can_run;

    // Compare against the value the timer takes on this increment
    assign roll = (cnt == per);
    assign nxt_cnt = roll ? 16'h0000 : 16'(cnt + 16'h0001);
    assign match = step && (nxt_cnt == pri_r);
    assign start_hit = step && dual && (pst_r == ocp_pkg::OCP_PW_WAIT) &&
      (nxt_cnt == pri_r);
    assign stop_hit = step && dual && (pst_r == ocp_pkg::OCP_PW_HIGH) &&
      (nxt_cnt == sec_r);
    assign cmp_evt = (simple && match) || start_hit || stop_hit;

    // Control word fields; fault status is not writable
    always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
        mode_r <= `OCP_RST_MODE;
        tsel_r <= 1'b0;
        sidl_r <= 1'b0;
      end else if (wr_ctl) begin
        mode_r <= wmode;
        tsel_r <= PWDATA_I[`OCP_BIT_TSEL];
        sidl_r <= PWDATA_I[`OCP_BIT_SIDL];
      end
    end

    // Primary register turns into the duty latch in PWM modes
    always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
        pri_r <= `OCP_RST_WORD;
      end else if (step && pwm && roll) begin
        pri_r <= sec_r;
      end else if (apb_wr && hit_pri[c] && !pwm) begin
        pri_r <= PWDATA_I[15:0];
      end
    end

    // Secondary register, the software-side duty buffer in PWM
    always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
        sec_r <= `OCP_RST_WORD;
      end else if (apb_wr && hit_sec[c]) begin
        sec_r <= PWDATA_I[15:0];
      end
    end

    // Dual compare pulse sequencer; a finished single pulse waits for a rewrite
    always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
        pst_r <= ocp_pkg::OCP_PW_WAIT;
      end else if (wr_ctl && (wmode == `OCP_MODE_SINGLE || wmode == `OCP_MODE_CONT)) begin
        pst_r <= ocp_pkg::OCP_PW_WAIT;
      end else begin
        case (pst_r)
          ocp_pkg::OCP_PW_WAIT: begin
            if (start_hit) begin
              pst_r <= ocp_pkg::OCP_PW_HIGH;
            end
          end
          ocp_pkg::OCP_PW_HIGH: begin
            if (stop_hit) begin
              pst_r <= (mode_r == `OCP_MODE_CONT) ? ocp_pkg::OCP_PW_WAIT
                                                 : ocp_pkg::OCP_PW_DONE;
            end
          end
          ocp_pkg::OCP_PW_DONE: begin
            pst_r <= ocp_pkg::OCP_PW_DONE;
          end
          default: begin
            pst_r <= ocp_pkg::OCP_PW_WAIT;
          end
        endcase
      end
    end

    // Output level; nothing moves without a timer step
    always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
        lvl_r <= 1'b0;
      end else if (step) begin
        case (mode_r)
          `OCP_MODE_LOW: begin
            if (match) begin
              lvl_r <= 1'b0;
            end
          end
          `OCP_MODE_HIGH: begin
            if (match) begin
              lvl_r <= 1'b1;
            end
          end
          `OCP_MODE_TGL: begin
            if (match) begin
              lvl_r <= !lvl_r;
            end
          end
          `OCP_MODE_SINGLE, `OCP_MODE_CONT: begin
            if (start_hit) begin
              lvl_r <= 1'b1;
            end else if (stop_hit) begin
              lvl_r <= 1'b0;
            end
          end
          `OCP_MODE_PWM, `OCP_MODE_PWM_FLT: begin
            // Duty above the period never matches, so the pin stays high
            if (roll) begin
              lvl_r <= (sec_r != 16'h0000);
            end else if (nxt_cnt == pri_r) begin
              lvl_r <= 1'b0;
            end
          end
          default: begin
            lvl_r <= lvl_r;
          end
        endcase
      end
    end

    // Fault latch; a new low on the pin beats any release
    always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
        flt_r <= 1'b0;
      end else if (mode_r == `OCP_MODE_PWM_FLT && !flt_s[c]) begin
        flt_r <= 1'b1;
      end else if (flt_r && flt_s[c] && (rearm_r || wr_pwm)) begin
        flt_r <= 1'b0;
      end
    end

    // Remembers a PWM rewrite made while the fault pin was still low
    always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
        rearm_r <= 1'b0;
      end else if (!flt_r) begin
        rearm_r <= 1'b0;
      end else if (wr_pwm) begin
        rearm_r <= 1'b1;
      end
    end

    // Compare event flag; a new event wins over a clear
    always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
        evt_r <= 1'b0;
      end else if (cmp_evt) begin
        evt_r <= 1'b1;
      end else if (apb_wr && hit_flag && PWDATA_I[c]) begin
        evt_r <= 1'b0;
      end
    end

    // Readback word of the control register
    always_comb begin
      ctl_v[c] = 16'h0000;
      ctl_v[c][2:0] = mode_r;
      ctl_v[c][`OCP_BIT_TSEL] = tsel_r;
      ctl_v[c][`OCP_BIT_FLT] = flt_r;
      ctl_v[c][`OCP_BIT_SIDL] = sidl_r;
    end

    assign sec_v[c] = sec_r;
    assign pri_v[c] = pri_r;
    assign evt_v[c] = evt_r;
    assign tsel_v[c] = tsel_r;
    assign roll_v[c] = step && pwm && roll;

    // Pin driver freezes its outputs while the clocks are stopped
    assign pif.level = lvl_r;
    assign pif.tristate = flt_r;
    assign pif.hold = CPU_SLEEP_I;
    ocp_pin_drv u_drv (
      .clk_i(REF_CLK_I),
      .rst_b_i(RST_B_I),
      .pin_if(pif.drv)
    );
    assign COMPARE_OUTPUT_PIN_O[c] = pif.pin;
    assign COMPARE_OUTPUT_PIN_OE_B_O[c] = pif.oe_b;
  end

  // Read mux; an address that hits nothing answers with an error
  always_comb begin
    rd_word = 16'h0000;
    any_hit = hit_flag;
    if (hit_flag) begin
      rd_word[N_CH-1:0] = evt_v;
    end
    for (int c = 0; c < N_CH; c++) begin
      if (hit_sec[c]) begin
        rd_word = sec_v[c];
      end
      if (hit_pri[c]) begin
        rd_word = pri_v[c];
      end
      if (hit_ctl[c]) begin
        rd_word = ctl_v[c];
      end
      any_hit = any_hit || hit_sec[c] || hit_pri[c] || hit_ctl[c];
    end
  end

  // Read data and error are captured in the setup cycle, so the access never waits
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      prdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end else if (apb_setup) begin
      prdata_r <= {16'h0000, rd_word};
      err_r <= !any_hit;
    end
  end

  // Timer flag requests from PWM rollovers, one per time base
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      tflag_r <= 2'h0;
    end else begin
      tflag_r[0] <= |(roll_v & ~tsel_v);
      tflag_r[1] <= |(roll_v & tsel_v);
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && err_r;
  assign TIMER_FLAG_SET_O = tflag_r;
endmodule

/* File: logic/ocp_params.svh */
// Register indices, field positions, mode codes and reset values of the compare block
`ifndef OCP_PARAMS_SVH
`define OCP_PARAMS_SVH
`define OCP_IDX_SEC_BASE 12'h180
`define OCP_IDX_PRI_BASE 12'h182
`define OCP_IDX_CTL_BASE 12'h184
`define OCP_IDX_CH_STRIDE 12'h006
`define OCP_IDX_FLAG 12'h1A0
`define OCP_BIT_TSEL 3
`define OCP_BIT_FLT 4
`define OCP_BIT_SIDL 13
`define OCP_MODE_OFF 3'h0
`define OCP_MODE_LOW 3'h1
`define OCP_MODE_HIGH 3'h2
`define OCP_MODE_TGL 3'h3
`define OCP_MODE_SINGLE 3'h4
`define OCP_MODE_CONT 3'h5
`define OCP_MODE_PWM 3'h6
`define OCP_MODE_PWM_FLT 3'h7
`define OCP_RST_WORD 16'h0000
`define OCP_RST_MODE 3'h0
`endif

/* File: logic/ocp_pkg.sv */
// Shared types of the compare block
package ocp_pkg;
  typedef logic [15:0] ocp_word_t;
  typedef enum logic [1:0] {OCP_PW_WAIT, OCP_PW_HIGH, OCP_PW_DONE} ocp_pulse_t;
endpackage

/* File: logic/ocp_pin_if.sv */
// Interface between channel logic and its pin driver
`timescale 1ns/1ps
interface ocp_pin_if;
  logic level;
  logic tristate;
  logic hold;
  logic pin;
  logic oe_b;
  modport ctl (output level, output tristate, output hold, input pin, input oe_b);
  modport drv (input level, input tristate, input hold, output pin, output oe_b);
endinterface

/* File: logic/ocp_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ocp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second; pins idle high after reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_r <= '1;
      q_o <= '1;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

/* File: logic/ocp_pin_drv.sv */
// Output pin driver with high-impedance release and sleep hold
`timescale 1ns/1ps
module ocp_pin_drv (
  input wire logic clk_i,
  input wire logic rst_b_i,
  ocp_pin_if.drv pin_if
);
  logic pin_r;
  logic oe_b_r;

  // While held, the pin keeps the level it had when the clocks stopped
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_r <= 1'b0;
      oe_b_r <= 1'b0;
    end else if (!pin_if.hold) begin
      pin_r <= pin_if.level;
      oe_b_r <= pin_if.tristate;
    end
  end

  assign pin_if.pin = pin_r;
  assign pin_if.oe_b = oe_b_r;
endmodule

/* File: bench/ocp_load.sv */
// Far-side model: load on the compare pins and the fault sources
`timescale 1ns/1ps
module ocp_load #(
  parameter int N_CH = 4
) (
  input wire logic clk_i,
  input wire logic [N_CH-1:0] pin_i,
  input wire logic [N_CH-1:0] oe_b_i,
  input wire logic [N_CH-1:0] trip_i,
  output logic [N_CH-1:0] fault_b_o,
  output logic [N_CH-1:0] line_o
);
  logic [N_CH-1:0] last_r;
  // Fault source pulls its line low only while tripped
  assign fault_b_o = ~trip_i;
  // Remember the last driven level of each pin
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < N_CH; c++) begin
      if (!oe_b_i[c]) begin
        last_r[c] <= pin_i[c];
      end
    end
  end
  // No keeper on a released pin, so it must not look like the last level
  assign line_o = (pin_i & ~oe_b_i) | (~last_r & oe_b_i);
endmodule

/* File: bench/ocp_chk.sv */
// Port-level assertions for the compare block
`timescale 1ns/1ps
module ocp_chk #(
  parameter int N_CH = 4
) (
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic [1:0][15:0] TIMER_COUNT_I,
  input wire logic [1:0][15:0] TIMER_PERIOD_VALUE_I,
  input wire logic [1:0] TIMER_TICK_I,
  input wire logic [1:0] TIMER_RUN_BIT_I,
  input wire logic [1:0] TIMER_IDLE_RUN_I,
  input wire logic CPU_IDLE_I,
  input wire logic CPU_SLEEP_I,
  input wire logic [N_CH-1:0] FAULT_INPUT_PIN_I,
  input wire logic [N_CH-1:0] COMPARE_OUTPUT_PIN_O,
  input wire logic [N_CH-1:0] COMPARE_OUTPUT_PIN_OE_B_O,
  input wire logic [1:0] TIMER_FLAG_SET_O
);
  logic roll0;
  logic tick_any;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // A rollover step of the first timer while awake
  assign roll0 = TIMER_TICK_I[0] && TIMER_RUN_BIT_I[0] && !CPU_SLEEP_I &&
    TIMER_COUNT_I[0] == TIMER_PERIOD_VALUE_I[0];
  assign tick_any = |TIMER_TICK_I;
  // Three samples deep, so the two-stage output pipeline has drained
  sequence slept_s;
    CPU_SLEEP_I [*3];
  endsequence
  sequence idle_frozen_s;
    (CPU_IDLE_I && TIMER_IDLE_RUN_I == 2'h0) [*3];
  endsequence
  a_flag_cause: assert property (TIMER_FLAG_SET_O[0] |-> $past(roll0))
    else $error("timer flag without rollover");
  a_flag_single: assert property (TIMER_FLAG_SET_O[0] && |TIMER_PERIOD_VALUE_I[0]
    |=> !TIMER_FLAG_SET_O[0]) else $error("timer flag too long");
  a_sleep_pin: assert property (slept_s |-> $stable(COMPARE_OUTPUT_PIN_O))
    else $error("pin moved in sleep");
  a_sleep_oe: assert property (slept_s |-> $stable(COMPARE_OUTPUT_PIN_OE_B_O))
    else $error("enable moved in sleep");
  a_idle_frozen: assert property (idle_frozen_s |-> $stable(COMPARE_OUTPUT_PIN_O))
    else $error("pin moved in idle");
  a_fault_float: assert property ($rose(COMPARE_OUTPUT_PIN_OE_B_O[1]) |->
    !$past(FAULT_INPUT_PIN_I[1], 3) || !$past(FAULT_INPUT_PIN_I[1], 4) ||
    !$past(FAULT_INPUT_PIN_I[1], 5)) else $error("float without fault");
  a_fault_hold: assert property ($fell(COMPARE_OUTPUT_PIN_OE_B_O[1]) |->
    $past(FAULT_INPUT_PIN_I[1], 3)) else $error("released under fault");
  a_pin_step: assert property ($changed(COMPARE_OUTPUT_PIN_O[0]) |-> $past(tick_any, 2))
    else $error("pin moved without timer step");
endmodule
bind ocp_top ocp_chk #(.N_CH(N_CH)) chk_u (.REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I),
  .TIMER_COUNT_I(TIMER_COUNT_I), .TIMER_PERIOD_VALUE_I(TIMER_PERIOD_VALUE_I),
  .TIMER_TICK_I(TIMER_TICK_I), .TIMER_RUN_BIT_I(TIMER_RUN_BIT_I),
  .TIMER_IDLE_RUN_I(TIMER_IDLE_RUN_I), .CPU_IDLE_I(CPU_IDLE_I), .CPU_SLEEP_I(CPU_SLEEP_I),
  .FAULT_INPUT_PIN_I(FAULT_INPUT_PIN_I), .COMPARE_OUTPUT_PIN_O(COMPARE_OUTPUT_PIN_O),
  .COMPARE_OUTPUT_PIN_OE_B_O(COMPARE_OUTPUT_PIN_OE_B_O), .TIMER_FLAG_SET_O(TIMER_FLAG_SET_O));

/* File: bench/ocp_top_tb.sv */
// Self-checking bench for the compare block
`timescale 1ns/1ps
module ocp_top_tb;
  localparam int N = 4;
  typedef struct {
    logic [2:0] m;
    logic s;
    logic [15:0] p;
    logic [15:0] per;
    logic pin;
    logic fl;
  } ocp_row_t;
  ocp_row_t rows [6] = '{'{3'h2, 1'h0, 16'h000A, 16'h00FF, 1'h1, 1'h1},
    '{3'h1, 1'h1, 16'h000A, 16'h00FF, 1'h0, 1'h1}, '{3'h3, 1'h0, 16'h000A, 16'h00FF, 1'h1, 1'h1},
    '{3'h3, 1'h0, 16'h0080, 16'h0020, 1'h1, 1'h0}, '{3'h0, 1'h0, 16'h000A, 16'h00FF, 1'h1, 1'h0},
    '{3'h3, 1'h1, 16'h000A, 16'h00FF, 1'h0, 1'h1}};
  logic [15:0] duty [3] = '{16'h0004, 16'h0000, 16'h0020};
  logic [15:0] high [3] = '{16'h0010, 16'h0000, 16'h0040};
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, slp = 0, idl = 0, tclr = 0;
  logic [15:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic rdy, err, er, v;
  logic [1:0][15:0] cnt = 0, per = 0;
  logic [1:0] run = 0, irun = 0, tf;
  logic [N-1:0] trip = 0, flt_b, pin, oe_b, line;
  int miscompares = 0, samples_checked = 0, hi, fl;
  initial forever #12.5 clk = ~clk;
  ocp_top #(.N_CH(N)) dut_u (.REF_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
    .PSLVERR_O(err), .TIMER_COUNT_I(cnt), .TIMER_PERIOD_VALUE_I(per), .TIMER_TICK_I(run),
    .TIMER_RUN_BIT_I(run), .TIMER_IDLE_RUN_I(irun), .CPU_IDLE_I(idl), .CPU_SLEEP_I(slp),
    .FAULT_INPUT_PIN_I(flt_b), .COMPARE_OUTPUT_PIN_O(pin), .COMPARE_OUTPUT_PIN_OE_B_O(oe_b),
    .TIMER_FLAG_SET_O(tf));
  ocp_load #(.N_CH(N)) load_u (.clk_i(clk), .pin_i(pin), .oe_b_i(oe_b), .trip_i(trip),
    .fault_b_o(flt_b), .line_o(line));
  // Two outside timers, one step per cycle while enabled
  always @(posedge clk) begin
    for (int t = 0; t < 2; t++) begin
      if (tclr) begin
        cnt[t] <= 16'h0000;
      end else if (run[t]) begin
        cnt[t] <= (cnt[t] == per[t]) ? 16'h0000 : cnt[t] + 16'h0001;
      end
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One APB transfer; answer taken at the edge where pready is seen high
  task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) begin
      @(posedge clk);
    end
    rd = prd;
    er = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Clear both outside timers while they stand still; one driver keeps the count
  task automatic tzero();
    tclr <= 1'b1;
    @(posedge clk);
    tclr <= 1'b0;
  endtask
  // Run timers for n cycles, counting pin c high and first-timer flags after s
  task automatic go(input logic [1:0] r, input int n, input int s, input int c);
    hi = 0;
    fl = 0;
    @(posedge clk);
    run <= r;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (i >= s) begin
        hi += int'(pin[c] === 1'b1);
        fl += int'(tf[0] === 1'b1);
      end
    end
    @(posedge clk);
    run <= 2'h0;
    @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Whole run needs about 1300 cycles
  initial begin
    repeat (10000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      per <= {2{rows[i].per}};
      tzero();
      apb(1'h1, 16'h0608, rows[i].p);
      apb(1'h1, 16'h0610, {12'h000, rows[i].s, rows[i].m});
      go({rows[i].s, !rows[i].s}, 40, 0, 0);
      chk(16'(pin[0]), 16'(rows[i].pin));
      apb(1'h0, 16'h0680, 16'h0000);
      chk(16'(rd[0]), 16'(rows[i].fl));
      apb(1'h1, 16'h0680, 16'h000F);
    end
    $display("match rows done");
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(16'(pin), 16'h0000);
    chk(16'(oe_b), 16'h0000);
    apb(1'h0, 16'h0610, 16'h0000);
    chk(rd[15:0], 16'h0000);
    $display("reset done");
    per <= {2{16'h001F}};
    tzero();
    apb(1'h1, 16'h0600, 16'h000F);
    apb(1'h1, 16'h0608, 16'h0005);
    apb(1'h1, 16'h0610, 16'h0004);
    go(2'h1, 100, 0, 0);
    chk(16'(hi), 16'h000A);
    go(2'h1, 100, 0, 0);
    chk(16'(hi), 16'h0000);
    apb(1'h1, 16'h0610, 16'h0004);
    go(2'h1, 100, 0, 0);
    chk(16'(hi), 16'h000A);
    tzero();
    apb(1'h1, 16'h0610, 16'h0005);
    go(2'h1, 96, 0, 0);
    chk(16'(hi), 16'h001E);
    $display("pulse done");
    per <= {2{16'h000F}};
    for (int i = 0; i < 3; i++) begin
      tzero();
      apb(1'h1, 16'h0618, duty[i]);
      if (i == 0) begin
        apb(1'h1, 16'h0628, 16'h0006);
      end
      go(2'h1, 84, 20, 1);
      chk(16'(hi), high[i]);
      chk(16'(fl), 16'h0004);
    end
    apb(1'h0, 16'h0620, 16'h0000);
    chk(rd[15:0], 16'h0020);
    apb(1'h1, 16'h0620, 16'h1234);
    apb(1'h0, 16'h0620, 16'h0000);
    chk(rd[15:0], 16'h0020);
    apb(1'h0, 16'h0680, 16'h0000);
    chk(16'(rd[1]), 16'h0000);
    $display("pwm done");
    apb(1'h1, 16'h0628, 16'h0007);
    trip[1] <= 1'b1;
    repeat (8) @(negedge clk);
    chk(16'(oe_b[1]), 16'h0001);
    chk(16'(line[1]), 16'h0000);
    apb(1'h0, 16'h0628, 16'h0000);
    chk(16'(rd[4]), 16'h0001);
    trip[1] <= 1'b0;
    repeat (10) @(negedge clk);
    chk(16'(oe_b[1]), 16'h0001);
    apb(1'h1, 16'h0628, 16'h0007);
    repeat (8) @(negedge clk);
    chk(16'(oe_b[1]), 16'h0000);
    chk(16'(line[1]), 16'h0001);
    apb(1'h0, 16'h0628, 16'h0000);
    chk(16'(rd[4]), 16'h0000);
    $display("fault done");
    per <= {2{16'h0007}};
    apb(1'h1, 16'h0608, 16'h0002);
    apb(1'h1, 16'h0610, 16'h0003);
    for (int k = 0; k < 2; k++) begin
      slp <= (k == 0);
      idl <= (k == 1);
      repeat (3) @(negedge clk);
      v = pin[0];
      go(2'h1, 24, 0, 0);
      chk(16'(hi), v ? 16'h0018 : 16'h0000);
      slp <= 1'b0;
      irun <= 2'h3;
      go(2'h1, 44, 12, 0);
      chk(16'(hi), 16'h0010);
      irun <= 2'h0;
    end
    // Stop-in-idle set: the channel stands still although its timer may run in idle
    apb(1'h1, 16'h0610, 16'h2003);
    irun <= 2'h3;
    @(negedge clk);
    v = pin[0];
    go(2'h1, 24, 0, 0);
    chk(16'(hi), v ? 16'h0018 : 16'h0000);
    idl <= 1'b0;
    irun <= 2'h0;
    $display("sleep idle done");
    apb(1'h0, 16'h0004, 16'h0000);
    chk(16'(er), 16'h0001);
    chk(rd[15:0], 16'h0000);
    $display("unmapped done");
    wrap_up();
  end
endmodule
